// [verilog/nsr_pkg.sv]
// Purpose: constants for the navigation subframe reporter
// Assumes: one 40 MHz clock, AHB-Lite register access
// Notes:   report = header word then payload words
package nsr_pkg;
    // ------------------------------------------------
    // Register map
    // ------------------------------------------------
    localparam logic [7:0]  NSR_CTRL_OFS   = 8'h00; // Enable
    localparam logic [7:0]  NSR_STAT_OFS   = 8'h04; // State, drops
    localparam logic [7:0]  NSR_COUNT_OFS  = 8'h08; // Reports sent
    localparam int          NSR_CTRL_EN_B  = 0;
    localparam logic [31:0] NSR_CTRL_RST   = 32'h0000_0000;
    // ------------------------------------------------
    // Constellation and signal codes
    // ------------------------------------------------
    localparam logic [7:0]  NSR_GNSS_GPS   = 8'h00;
    localparam logic [7:0]  NSR_GNSS_GAL   = 8'h02;
    localparam logic [7:0]  NSR_GNSS_BDS   = 8'h03;
    localparam logic [7:0]  NSR_GNSS_GLO   = 8'h06;
    localparam logic [7:0]  NSR_SIG_L1CA   = 8'h00;
    localparam logic [7:0]  NSR_SIG_L2CL   = 8'h03;
    localparam logic [7:0]  NSR_SIG_L2CM   = 8'h04;
    localparam logic [7:0]  NSR_SIG_E1B    = 8'h01;
    localparam logic [7:0]  NSR_SIG_E5BI   = 8'h05;
    localparam logic [7:0]  NSR_SV_UNKNOWN = 8'hff;
    // ------------------------------------------------
    // Framing
    // ------------------------------------------------
    localparam logic [8:0]  NSR_BITS_300   = 9'h12c; // L1, L2C, BDS
    localparam logic [8:0]  NSR_BITS_GAL   = 9'h100; // Page pair
    localparam logic [8:0]  NSR_BITS_GLO   = 9'h055; // 85-bit string
    localparam logic [5:0]  NSR_BPW_30     = 6'h1e;  // Pad in top 2
    localparam logic [5:0]  NSR_BPW_32     = 6'h20;
    localparam logic [4:0]  NSR_LNAV_INV   = 5'h18;  // Bits 1..24
    localparam logic [3:0]  NSR_WORDS_10   = 4'ha;
    localparam logic [3:0]  NSR_WORDS_GAL  = 4'h8;
    localparam logic [3:0]  NSR_WORDS_GLO  = 4'h4;
    localparam int          NSR_MEM_DEPTH  = 10;
    localparam int          NSR_BUF_W      = 33;     // Data plus last

    typedef enum logic [2:0] {
        NSR_FMT_NONE, NSR_FMT_L1, NSR_FMT_L2C,
        NSR_FMT_BDS, NSR_FMT_GAL, NSR_FMT_GLO
    } nsr_fmt_t;

    typedef enum logic {NSR_ST_COLLECT, NSR_ST_EMIT} nsr_state_t;
endpackage

// [verilog/nsr_reporter.sv]
// Purpose: pack decoded subframe bits into host reports
// Assumes: bit source on hclk, honours sf_ready
// Notes:   header [31:24] gnss [23:16] sv [15:8] sig [7:0] count
//
// The placing of the registers and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
module nsr_reporter
    import nsr_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // Decoded bit stream
    input  wire logic        sf_valid,
    input  wire logic        sf_bit,
    input  wire logic        sf_start,
    input  wire logic        sf_end,
    input  wire logic        sf_parity_ok,
    input  wire logic        sf_d30_prev,
    input  wire logic [7:0]  sf_gnss,
    input  wire logic [7:0]  sf_sig,
    input  wire logic [7:0]  sf_sv,
    input  wire logic        sf_sv_known,
    input  wire logic        sf_fnum_known,
    input  wire logic [7:0]  sf_frame,
    input  wire logic [15:0] sf_superframe,
    output logic             sf_ready,
    // Report word stream
    output logic             rpt_valid,
    output logic [31:0]      rpt_data,
    output logic             rpt_last,
    input  wire logic        rpt_ready
);
    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    // Map constellation and signal to a word layout
    function automatic nsr_fmt_t fmt_of(input logic [7:0] g,
                                        input logic [7:0] s);
        fmt_of = NSR_FMT_NONE;
        if (g == NSR_GNSS_GPS && s == NSR_SIG_L1CA)
            fmt_of = NSR_FMT_L1;
        else if (g == NSR_GNSS_GPS &&
                 (s == NSR_SIG_L2CL || s == NSR_SIG_L2CM))
            fmt_of = NSR_FMT_L2C;
        else if (g == NSR_GNSS_BDS)
            fmt_of = NSR_FMT_BDS;
        else if (g == NSR_GNSS_GAL &&
                 (s == NSR_SIG_E1B || s == NSR_SIG_E5BI))
            fmt_of = NSR_FMT_GAL;
        else if (g == NSR_GNSS_GLO)
            fmt_of = NSR_FMT_GLO;
    endfunction

    // ------------------------------------------------
    // Registers and state
    // ------------------------------------------------
    nsr_state_t  state_reg;              // Collect or emit
    nsr_fmt_t    fmt_reg;                // Layout of subframe
    logic        en_reg;                 // Reporting enable
    logic [15:0] drop_reg;               // Dropped subframes
    logic [15:0] sent_reg;               // Reports emitted
    logic [31:0] mem [NSR_MEM_DEPTH];    // Payload words
    logic [31:0] acc_reg;                // Word being built
    logic [5:0]  wbit_reg;               // Bits in acc_reg
    logic [3:0]  widx_reg;               // Words stored
    logic [8:0]  nbit_reg;               // Bits this subframe
    logic        ovf_reg;                // Too many bits
    logic        inv_reg;                // Previous D30 level
    logic        busy_reg;               // Inside a subframe
    logic [7:0]  gnss_reg;
    logic [7:0]  sig_reg;
    logic [7:0]  sv_reg;
    logic [31:0] extra_reg;              // GLONASS fourth word
    logic [3:0]  cnt_reg;                // Payload word count
    logic [3:0]  eidx_reg;               // Emit position
    logic        hdr_reg;                // Header still due
    // Bus data phase
    logic        wr_pend_reg;
    logic [7:0]  wr_addr_reg;

    // ------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------
    logic        acc_phase;
    logic [7:0]  a_ofs;
    assign acc_phase = hsel && htrans[1] && hready;
    assign a_ofs     = haddr[7:0];

    // Answer always OKAY with no wait
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Read data latched in the address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (acc_phase && !hwrite)
        begin
            if (a_ofs == NSR_CTRL_OFS)
                hrdata <= {31'h0000_0000, en_reg};
            else if (a_ofs == NSR_STAT_OFS)
                hrdata <= {drop_reg, 14'h0000, busy_reg,
                           state_reg == NSR_ST_EMIT};
            else if (a_ofs == NSR_COUNT_OFS)
                hrdata <= {16'h0000, sent_reg};
            else
                hrdata <= 32'h0000_0000;  // Unmapped reads zero
        end
    end

    // Write address held over to the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end
        else
        begin
            wr_pend_reg <= acc_phase && hwrite;
            wr_addr_reg <= a_ofs;
        end
    end

    // Enable bit; read by the end check, so clearing it also drops the subframe in progress
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            en_reg <= NSR_CTRL_RST[NSR_CTRL_EN_B];
        else if (wr_pend_reg && wr_addr_reg == NSR_CTRL_OFS)
            en_reg <= hwdata[NSR_CTRL_EN_B];
    end

    // ------------------------------------------------
    // Bit assembly
    // ------------------------------------------------
    logic        take;
    logic        dbit;
    logic [31:0] acc_next;
    logic [5:0]  bpw;
    logic        wfull;
    nsr_fmt_t    fmt_cur;
    logic [8:0]  want_bits;
    logic        good;

    assign take     = sf_valid && sf_ready;
    assign fmt_cur  = sf_start ? fmt_of(sf_gnss, sf_sig) : fmt_reg;
    // LNAV data bits 1..24 flip when the last D30 was set
    assign dbit     = sf_bit ^ (fmt_cur == NSR_FMT_L1 &&
                      (sf_start ? sf_d30_prev : inv_reg) &&
                      (sf_start ? 1'b1 : wbit_reg < 6'(NSR_LNAV_INV)));
    assign acc_next = {(sf_start ? 31'h0 : acc_reg[30:0]), dbit};
    // Thirty-bit words leave the top two bits as zero pad
    assign bpw      = (fmt_cur == NSR_FMT_L1 || fmt_cur == NSR_FMT_BDS)
                    ? NSR_BPW_30 : NSR_BPW_32;
    assign wfull    = (sf_start ? 6'h01 : wbit_reg + 6'h01) == bpw;

    // Expected length per layout
    always_comb
    begin
        case (fmt_reg)
            NSR_FMT_L1, NSR_FMT_BDS: want_bits = NSR_BITS_300;
            NSR_FMT_L2C:             want_bits = NSR_BITS_300;
            NSR_FMT_GAL:             want_bits = NSR_BITS_GAL;
            NSR_FMT_GLO:             want_bits = NSR_BITS_GLO;
            default:                 want_bits = 9'h000;
        endcase
    end

    // Only whole, parity-clean subframes of a known layout pass
    assign good = en_reg && sf_parity_ok && !ovf_reg &&
                  fmt_reg != NSR_FMT_NONE &&
                  nbit_reg == want_bits;

    // Shift bits in and store each word as it fills
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            acc_reg  <= 32'h0000_0000;
            wbit_reg <= 6'h00;
            widx_reg <= 4'h0;
            nbit_reg <= 9'h000;
            ovf_reg  <= 1'b0;
            inv_reg  <= 1'b0;
        end
        else if (take && (busy_reg || sf_start))
        begin
            inv_reg  <= sf_start ? sf_d30_prev : wfull ? sf_bit : inv_reg; // Last D30
            nbit_reg <= sf_start ? 9'h001 : nbit_reg + 9'h001;
            if (sf_start)
                ovf_reg <= 1'b0;
            if (wfull || sf_end)
            begin
                acc_reg  <= 32'h0000_0000;
                wbit_reg <= 6'h00;
                widx_reg <= sf_start ? 4'h1 : widx_reg + 4'h1;
                if (!sf_start && widx_reg == 4'(NSR_MEM_DEPTH))
                    ovf_reg <= 1'b1;  // Longer than any layout
            end
            else
            begin
                acc_reg  <= acc_next;
                wbit_reg <= sf_start ? 6'h01 : wbit_reg + 6'h01;
                widx_reg <= sf_start ? 4'h0 : widx_reg;
            end
        end
    end

    // Payload store; a short last word is left-justified
    always_ff @(posedge hclk)
    begin
        if (take && (busy_reg || sf_start) && (wfull || sf_end) &&
            (sf_start || widx_reg < 4'(NSR_MEM_DEPTH)))
            mem[sf_start ? 4'h0 : widx_reg] <= wfull ? acc_next :
                acc_next << (bpw - wbit_reg - 6'h01);
    end

    // Subframe identity captured on its first bit
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fmt_reg   <= NSR_FMT_NONE;
            gnss_reg  <= 8'h00;
            sig_reg   <= 8'h00;
            sv_reg    <= 8'h00;
            extra_reg <= 32'h0000_0000;
        end
        else if (take && sf_start)
        begin
            fmt_reg  <= fmt_of(sf_gnss, sf_sig);
            gnss_reg <= sf_gnss;
            sig_reg  <= sf_sig;
            sv_reg   <= (sf_gnss == NSR_GNSS_GLO && !sf_sv_known)
                      ? NSR_SV_UNKNOWN : sf_sv;
            extra_reg <= sf_fnum_known
                       ? {sf_superframe, 8'h00, sf_frame}
                       : 32'h0000_0000;
        end
    end

    // ------------------------------------------------
    // Control: collect, then emit
    // ------------------------------------------------
    logic buf_in_ready;
    logic push;
    assign push = state_reg == NSR_ST_EMIT && buf_in_ready;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg <= NSR_ST_COLLECT;
            busy_reg  <= 1'b0;
            sf_ready  <= 1'b0;
            cnt_reg   <= 4'h0;
            eidx_reg  <= 4'h0;
            hdr_reg   <= 1'b0;
            drop_reg  <= 16'h0000;
            sent_reg  <= 16'h0000;
        end
        else
        begin
            case (state_reg)
                NSR_ST_COLLECT:
                begin
                    sf_ready <= sf_ready || !busy_reg;
                    if (take && sf_start)
                        busy_reg <= 1'b1;
                    // End checks run the cycle after the last bit
                    if (take && sf_end && (busy_reg || sf_start))
                        sf_ready <= 1'b0;
                    if (!sf_ready && busy_reg)
                    begin
                        busy_reg <= 1'b0;
                        if (good)
                        begin
                            state_reg <= NSR_ST_EMIT;
                            hdr_reg   <= 1'b1;
                            eidx_reg  <= 4'h0;
                            cnt_reg   <= fmt_reg == NSR_FMT_GAL
                                ? NSR_WORDS_GAL : fmt_reg == NSR_FMT_GLO
                                ? NSR_WORDS_GLO : NSR_WORDS_10;
                        end
                        else
                        begin
                            drop_reg <= drop_reg + 16'h0001;
                            sf_ready <= 1'b1;
                        end
                    end
                end
                NSR_ST_EMIT:
                begin
                    sf_ready <= 1'b0;   // Source waits for drain
                    if (push)
                    begin
                        hdr_reg <= 1'b0;
                        if (!hdr_reg)
                            eidx_reg <= eidx_reg + 4'h1;
                        if (!hdr_reg && eidx_reg + 4'h1 == cnt_reg)
                        begin
                            state_reg <= NSR_ST_COLLECT;
                            sent_reg  <= sent_reg + 16'h0001;
                            sf_ready  <= 1'b1;
                        end
                    end
                end
                default: state_reg <= NSR_ST_COLLECT;
            endcase
        end
    end

    // Word offered to the buffer
    logic [31:0] emit_word;
    always_comb
    begin
        if (hdr_reg)
            emit_word = {gnss_reg, sv_reg, sig_reg, 4'h0, cnt_reg};
        else if (fmt_reg == NSR_FMT_GLO && eidx_reg == 4'h3)
            emit_word = extra_reg;
        else
            emit_word = mem[eidx_reg];  // Alert pages as received
    end

    // ------------------------------------------------
    // Two-entry output buffer
    // ------------------------------------------------
    // Head feeds the port directly; spare catches a word
    // pushed while the host stalls, so nothing is lost.
    logic [NSR_BUF_W-1:0] spare_reg;
    logic                 spare_v_reg;
    logic                 pop;
    assign pop          = rpt_valid && rpt_ready;
    assign buf_in_ready = !spare_v_reg;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rpt_valid   <= 1'b0;
            rpt_data    <= 32'h0000_0000;
            rpt_last    <= 1'b0;
            spare_reg   <= '0;
            spare_v_reg <= 1'b0;
        end
        else if (!rpt_valid || pop)
        begin
            if (spare_v_reg)
            begin
                {rpt_last, rpt_data} <= spare_reg;
                rpt_valid   <= 1'b1;
                spare_v_reg <= 1'b0;
            end
            else if (push)
            begin
                rpt_data  <= emit_word;
                rpt_last  <= !hdr_reg && eidx_reg + 4'h1 == cnt_reg;
                rpt_valid <= 1'b1;
            end
            else
                rpt_valid <= 1'b0;
        end
        else if (push)
        begin
            spare_reg   <= {!hdr_reg && eidx_reg + 4'h1 == cnt_reg,
                            emit_word};
            spare_v_reg <= 1'b1;
        end
    end
endmodule

// [testbench/nsr_monitor.sv]
// Purpose: port-level checks of the subframe reporter
// Assumes: nsr_reporter ports, one clock, async low reset
// Notes:   bound to every nsr_reporter at the foot of this file
`timescale 1ns/1ps
module nsr_monitor
    import nsr_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        sf_valid,
    input wire logic        sf_end,
    input wire logic        sf_parity_ok,
    input wire logic        sf_ready,
    input wire logic        rpt_valid,
    input wire logic [31:0] rpt_data,
    input wire logic        rpt_last,
    input wire logic        rpt_ready
);
    // ------------------------------------------------
    // Report framing tracker
    // ------------------------------------------------
    logic       hdr_reg;  // Next word taken is a header
    logic [7:0] cnt_reg;  // Payload words taken so far
    logic [7:0] want_reg; // Count announced by the header
    wire        take    = rpt_valid && rpt_ready;
    wire        bad_end = sf_valid && sf_ready && sf_end && !sf_parity_ok;

    // Follow headers and payload as the host takes them
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hdr_reg  <= 1'b1;
            cnt_reg  <= 8'h00;
            want_reg <= 8'h00;
        end
        else if (take)
        begin
            hdr_reg <= rpt_last;
            if (hdr_reg)
            begin
                cnt_reg  <= 8'h00;
                want_reg <= rpt_data[7:0];
            end
            else
            begin
                cnt_reg <= cnt_reg + 8'h01;
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    stall_hold_a: assert property (rpt_valid && !rpt_ready |=>
        rpt_valid && $stable(rpt_data) && $stable(rpt_last)) else $error("word lost in stall");
    end_drop_a: assert property (sf_valid && sf_ready && sf_end |=> !sf_ready)
        else $error("ready held after end bit");
    bad_return_a: assert property (bad_end |=> !sf_ready ##[1:2] sf_ready)
        else $error("ready not back after drop");
    bad_silent_a: assert property (bad_end && !rpt_valid |=> !rpt_valid [*4])
        else $error("report for bad subframe");
    hdr_pad_a: assert property (rpt_valid && hdr_reg |-> rpt_data[7:4] == 4'h0)
        else $error("header spare bits set");
    gps_count_a: assert property (rpt_valid && hdr_reg && rpt_data[31:24] == NSR_GNSS_GPS
        |-> rpt_data[7:0] == 8'h0a) else $error("gps count wrong");
    bds_count_a: assert property (rpt_valid && hdr_reg && rpt_data[31:24] == NSR_GNSS_BDS
        |-> rpt_data[7:0] == 8'h0a) else $error("beidou count wrong");
    gal_count_a: assert property (rpt_valid && hdr_reg && rpt_data[31:24] == NSR_GNSS_GAL
        |-> rpt_data[7:0] == 8'h08) else $error("galileo count wrong");
    glo_count_a: assert property (rpt_valid && hdr_reg && rpt_data[31:24] == NSR_GNSS_GLO
        |-> rpt_data[7:0] == 8'h04) else $error("glonass count wrong");
    last_count_a: assert property (rpt_valid && rpt_last
        |-> !hdr_reg && cnt_reg + 8'h01 == want_reg) else $error("last flag misplaced");

    // Main scenarios reached
    cover property (take && rpt_last);
    cover property (rpt_valid && !rpt_ready);
    cover property (bad_end);
endmodule

bind nsr_reporter nsr_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .sf_valid(sf_valid),
    .sf_end(sf_end), .sf_parity_ok(sf_parity_ok), .sf_ready(sf_ready),
    .rpt_valid(rpt_valid), .rpt_data(rpt_data), .rpt_last(rpt_last), .rpt_ready(rpt_ready));

// [testbench/nsr_host_model.sv]
// Purpose: host that takes report words, promptly or slowly
// Assumes: valid/ready stream, word taken when both high
// Notes:   keeps raw words; pad masking is left to the bench
`timescale 1ns/1ps
module nsr_host_model
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        rpt_valid,
    input  wire logic [31:0] rpt_data,
    input  wire logic        rpt_last,
    output logic             rpt_ready,
    input  wire logic        stall
);
    logic [31:0] words [$]; // Every word taken, header first
    logic [2:0]  tick_reg;  // Paces the slow mode
    int          nrep;      // Reports ended by a last word

    // Slow mode accepts one cycle in eight to fill the buffer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tick_reg  <= 3'h0;
            rpt_ready <= 1'b0;
        end
        else
        begin
            tick_reg  <= tick_reg + 3'h1;
            rpt_ready <= stall ? (tick_reg == 3'h0) : 1'b1;
        end
    end

    // Store words unparsed: header gives layout, pad is never trusted
    always @(posedge hclk)
    begin
        if (hresetn && rpt_valid && rpt_ready)
        begin
            words.push_back(rpt_data);
            if (rpt_last)
                nrep++;
        end
    end
endmodule

// [testbench/tb_top.sv]
// Purpose: self-checking bench for the subframe reporter
// Assumes: 40 MHz hclk, zero-wait register slave
// Notes:   expected words are rebuilt from the generated bits
`timescale 1ns/1ps
module tb_top
    import nsr_pkg::*;
;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, stall = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rpt_data, rd;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic hreadyout, hresp, sf_ready, rpt_valid, rpt_last, rpt_ready;
    logic sf_valid = 1'b0, sf_bit = 1'b0, sf_start = 1'b0, sf_end = 1'b0, sf_pok = 1'b0;
    logic sf_d30 = 1'b0, sf_svk = 1'b0, sf_fnk = 1'b0;
    logic [7:0]  sf_gnss = '0, sf_sig = '0, sf_sv = '0;
    int mismatches = 0, check_count = 0, cyc = 0, base, drops;
    // Case table: GPS L1, L2CL, L2CM, BeiDou, E1-B, E5b-I, GLONASS twice
    logic [7:0] gn [8] = '{NSR_GNSS_GPS, NSR_GNSS_GPS, NSR_GNSS_GPS, NSR_GNSS_BDS,
        NSR_GNSS_GAL, NSR_GNSS_GAL, NSR_GNSS_GLO, NSR_GNSS_GLO};
    logic [7:0] sg [8] = '{NSR_SIG_L1CA, NSR_SIG_L2CL, NSR_SIG_L2CM, 8'h00,
        NSR_SIG_E1B, NSR_SIG_E5BI, 8'h00, 8'h00};
    int nb [8] = '{300, 300, 300, 300, 256, 256, 85, 85};
    int bp [8] = '{30, 32, 32, 30, 32, 32, 32, 32};
    int nw [8] = '{10, 10, 10, 10, 8, 8, 4, 4};

    nsr_reporter u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sf_valid(sf_valid),
        .sf_bit(sf_bit), .sf_start(sf_start), .sf_end(sf_end), .sf_parity_ok(sf_pok),
        .sf_d30_prev(sf_d30), .sf_gnss(sf_gnss), .sf_sig(sf_sig), .sf_sv(sf_sv),
        .sf_sv_known(sf_svk), .sf_fnum_known(sf_fnk), .sf_frame(8'h05),
        .sf_superframe(16'h0123), .sf_ready(sf_ready), .rpt_valid(rpt_valid),
        .rpt_data(rpt_data), .rpt_last(rpt_last), .rpt_ready(rpt_ready));
    nsr_host_model u_host (.hclk(hclk), .hresetn(hresetn), .rpt_valid(rpt_valid),
        .rpt_data(rpt_data), .rpt_last(rpt_last), .rpt_ready(rpt_ready), .stall(stall));

    // ------------------------------------------------
    // Clock, watchdog, helpers
    // ------------------------------------------------
    initial forever #12.5 hclk = ~hclk;
    // Whole run needs about 3300 cycles; a hang ends here
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // Single AHB-Lite transfer; waits on hready in both phases
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (!hreadyout);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (!hreadyout);
        rd = hrdata;
    endtask

    // Fixed air bits; GPS D30 kept at 0
    function automatic logic bitv(input int c, input int i);
        if (c == 0 && i % 30 == 29)
            return 1'b0;
        if ((c == 4 || c == 5) && i == 1)
            return 1'b1; // Page type 1 marks an alert page
        return ((i * 13 + c * 5) % 7) < 3;
    endfunction

    // Send one subframe bit by bit, holding each until accepted
    task automatic send_sf(input int c, input logic pok, input logic d30);
        for (int i = 0; i < nb[c]; i++)
        begin
            sf_valid <= 1'b1;
            sf_bit <= bitv(c, i);
            sf_start <= (i == 0);
            sf_end <= (i == nb[c] - 1);
            sf_pok <= pok;
            sf_d30 <= d30;
            sf_gnss <= gn[c];
            sf_sig <= sg[c];
            sf_sv <= 8'h10 + 8'(c);
            sf_svk <= (c != 6);
            sf_fnk <= (c == 6);
            do @(posedge hclk); while (!sf_ready);
        end
        sf_valid <= 1'b0;
        sf_end <= 1'b0;
    endtask

    // Wait for a dropped subframe's window and see no report
    task automatic expect_none(input int c, input logic pok);
        base = u_host.words.size();
        send_sf(c, pok, 1'b0);
        repeat (30) @(posedge hclk);
        chk(32'(u_host.words.size()), 32'(base), "words from dropped subframe");
    endtask

    // Rebuild header and payload from the sent bits and compare
    task automatic expect_report(input int c, input logic d30);
        logic [31:0] e, m;
        logic [7:0]  sv;
        base = u_host.words.size();
        stall <= c[0];
        send_sf(c, 1'b1, d30);
        while (u_host.words.size() < base + nw[c] + 1) @(posedge hclk);
        sv = (c == 6) ? NSR_SV_UNKNOWN : 8'h10 + 8'(c);
        chk(u_host.words[base], {gn[c], sv, sg[c], 8'(nw[c])}, "header");
        for (int k = 0; k < nw[c]; k++)
        begin
            e = '0;
            m = '0;
            for (int j = 0; j < bp[c]; j++)
                if (k * bp[c] + j < nb[c])
                begin
                    e[bp[c] - 1 - j] = bitv(c, k * bp[c] + j);
                    m[bp[c] - 1 - j] = 1'b1;
                end
            if (c == 0 && k == 0 && d30)
                e[29:6] = ~e[29:6];
            if (k == 3 && gn[c] == NSR_GNSS_GLO)
            begin
                e = (c == 6) ? 32'h0123_0005 : 32'h0;
                m = '1;
            end
            chk(u_host.words[base + 1 + k] & m, e, "payload word");
        end
    endtask

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        ahb(1'b0, 32'(NSR_CTRL_OFS), '0);
        chk(rd, NSR_CTRL_RST, "ctrl reset value");
        ahb(1'b0, 32'h0000_000c, '0);
        chk(rd, 32'h0, "unmapped read");
        chk(32'(hresp), 32'h0, "hresp");
        expect_none(0, 1'b1);
        ahb(1'b0, 32'(NSR_STAT_OFS), '0);
        drops = int'(rd[31:16]);
        ahb(1'b1, 32'(NSR_CTRL_OFS), 32'h1);
        ahb(1'b0, 32'(NSR_CTRL_OFS), '0);
        chk(rd, 32'h1, "ctrl readback");
        expect_report(0, 1'b1);
        for (int c = 1; c < 8; c++)
            expect_report(c, 1'b0);
        stall <= 1'b0;
        expect_none(0, 1'b0);
        expect_none(3, 1'b0);
        ahb(1'b0, 32'(NSR_STAT_OFS), '0);
        chk({16'h0, rd[31:16]}, 32'(drops + 2), "drop count");
        ahb(1'b0, 32'(NSR_COUNT_OFS), '0);
        chk({16'h0, rd[15:0]}, 32'd8, "reports sent");
        chk(32'(u_host.nrep), 32'd8, "reports ended");
        results();
    end
endmodule
